// ==== logic/fes_consts.svh ====
// offsets, command codes and timing figures of the erase sequencer
`ifndef FES_CONSTS_SVH
`define FES_CONSTS_SVH
`define FES_REG_CMD 6'h00
`define FES_REG_ADDR 6'h01
`define FES_REG_STAT 6'h02
`define FES_REG_RDATA 6'h03
`define FES_STAT_BUSY 0
`define FES_STAT_RB 1
`define FES_STAT_REFUSED 2
`define FES_STAT_WINDOW 3
`define FES_UNLOCK_A1 20'h0_0555
`define FES_UNLOCK_D1 16'h00AA
`define FES_UNLOCK_A2 20'h0_02AA
`define FES_UNLOCK_D2 16'h0055
`define FES_CMD_SETUP 16'h0080
`define FES_CMD_CHIP 16'h0010
`define FES_CMD_SECTOR 16'h0030
`define FES_CMD_SUSPEND 16'h00B0
`define FES_CMD_RESUME 16'h0030
`define FES_CMD_RESET 16'h00F0
`define FES_CLK_NS 20
`define FES_WIN_NS 50000
`define FES_WE_LOW_NS 35
`define FES_RD_ACC_NS 70
`define FES_HWRST_NS 500
`define FES_RST_DATA 16'h0000
`endif

// ==== logic/fes_pkg.sv ====
// types shared by the erase sequencer and its bus-cycle engine
package fes_pkg;
  typedef enum logic [3:0]
  {
    OP_NONE = 4'b0000,
    OP_CHIP = 4'b0001,
    OP_SECTOR = 4'b0010,
    OP_EXTRA = 4'b0011,
    OP_SUSPEND = 4'b0100,
    OP_RESUME = 4'b0101,
    OP_RESET = 4'b0110,
    OP_READ = 4'b0111,
    OP_HWRST = 4'b1000
  } fes_op_e;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT = 2'b10,
    ST_HWRST = 2'b11
  } fes_st_e;
  typedef enum logic [1:0]
  {
    BC_IDLE = 2'b00,
    BC_SETUP = 2'b01,
    BC_PULSE = 2'b10,
    BC_HOLD = 2'b11
  } fes_bc_e;
  typedef struct packed {
    fes_bc_e st;
    logic rd;
    logic [7:0] cnt;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic done;
  } fes_bc_s;
  typedef struct packed {
    fes_st_e st;
    fes_op_e op;
    logic [2:0] step;
    logic [19:0] faddr;
    logic [15:0] rdata;
    logic refused;
    logic win;
    logic [15:0] gap;
    logic [15:0] rcnt;
    logic ap_valid;
    logic ap_wr;
    logic [5:0] ap_idx;
    logic [31:0] hrdata;
    logic rb_s1;
    logic rb_s2;
  } fes_ctl_s;
endpackage : fes_pkg

// ==== logic/fes_bus_cycle.sv ====
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/100ps
`include "fes_consts.svh"
module fes_bus_cycle
  import fes_pkg::*;
#(
  parameter int WE_CYC = (`FES_WE_LOW_NS + `FES_CLK_NS - 1) / `FES_CLK_NS,
  parameter int RD_CYC = (`FES_RD_ACC_NS + `FES_CLK_NS - 1) / `FES_CLK_NS
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic is_read,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_i,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  fes_bc_s r;
  fes_bc_s next_r;

  // reads keep oe low two extra cycles to cover the input synchroniser
  localparam logic [7:0] WE_LAST = 8'(WE_CYC - 1);
  localparam logic [7:0] RD_LAST = 8'(RD_CYC + 1);

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.dq_s1 = flash_dq_i;
    next_r.dq_s2 = r.dq_s1;
    case (r.st)
      BC_IDLE:
      begin
        if (start)
        begin
          next_r.st = BC_SETUP;
          next_r.rd = is_read;
          next_r.addr = addr;
          next_r.wdata = wdata;
        end
      end
      BC_SETUP:
      begin
        next_r.st = BC_PULSE;
        next_r.cnt = 8'h00;
      end
      BC_PULSE:
      begin
        next_r.cnt = r.cnt + 8'h01;
        if (r.cnt == (r.rd ? RD_LAST : WE_LAST))
        begin
          next_r.st = BC_HOLD;
          if (r.rd)
          begin
            next_r.rdata = r.dq_s2;
          end
        end
      end
      BC_HOLD:
      begin
        next_r.st = BC_IDLE;
        next_r.done = 1'b1;
      end
      default:
      begin
        next_r.st = BC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign rdata = r.rdata;
  assign flash_addr = r.addr;
  // the upper byte is driven but carries nothing in command cycles
  assign flash_dq_o = r.wdata;
  assign flash_dq_oe = !r.rd && (r.st != BC_IDLE);
  assign flash_ce_n = (r.st == BC_IDLE);
  assign flash_we_n = !(r.st == BC_PULSE && !r.rd);
  assign flash_oe_n = !(r.st == BC_PULSE && r.rd);

  AST_WE_INSIDE_CE: assert property (@(posedge clk) disable iff (sys_rst)
    !flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe outside chip select");
  AST_CYCLE_DONE: assert property (@(posedge clk) disable iff (sys_rst)
    (start && r.st == BC_IDLE) |-> ##[3:12] done)
    else $error("bus cycle did not finish in time");
endmodule : fes_bus_cycle

// ==== logic/fes_ctrl.sv ====
// erase command sequencer: AHB-Lite register slave driving flash pins
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps
`include "fes_consts.svh"
module fes_ctrl
  import fes_pkg::*;
#(
  parameter int WIN_CYC = `FES_WIN_NS / `FES_CLK_NS,
  parameter int HWRST_CYC = (`FES_HWRST_NS + `FES_CLK_NS - 1) / `FES_CLK_NS,
  parameter int WR_CYC = 6
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_i,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  input wire logic ready_busy_out
);
  fes_ctl_s r;
  fes_ctl_s next_r;
  logic cyc_start;
  logic cyc_read;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic [35:0] cyc_word;

  // an extra sector must land well inside the window, allowing for the
  // time the write itself takes before its strobe edge
  localparam logic [15:0] GAP_LIMIT = 16'(WIN_CYC - WR_CYC);
  localparam logic [15:0] WIN_LAST = 16'(WIN_CYC);
  localparam logic [15:0] RST_LAST = 16'(HWRST_CYC - 1);

  function automatic logic [2:0] op_len(input fes_op_e op);
    case (op)
      OP_CHIP, OP_SECTOR: op_len = 3'd6;
      default: op_len = 3'd1;
    endcase
  endfunction : op_len

  function automatic logic [35:0] op_word(input fes_op_e op,
    input logic [2:0] step, input logic [19:0] sa);
    op_word = {20'h0_0000, `FES_RST_DATA};
    case (op)
      OP_CHIP, OP_SECTOR:
      begin
        case (step)
          3'd0, 3'd3: op_word = {`FES_UNLOCK_A1, `FES_UNLOCK_D1};
          3'd1, 3'd4: op_word = {`FES_UNLOCK_A2, `FES_UNLOCK_D2};
          3'd2: op_word = {`FES_UNLOCK_A1, `FES_CMD_SETUP};
          default: op_word = (op == OP_CHIP) ?
            {`FES_UNLOCK_A1, `FES_CMD_CHIP} : {sa, `FES_CMD_SECTOR};
        endcase
      end
      OP_EXTRA: op_word = {sa, `FES_CMD_SECTOR};
      OP_SUSPEND: op_word = {20'h0_0000, `FES_CMD_SUSPEND};
      OP_RESUME: op_word = {20'h0_0000, `FES_CMD_RESUME};
      OP_RESET: op_word = {20'h0_0000, `FES_CMD_RESET};
      OP_READ: op_word = {sa, 16'h0000};
      default: op_word = {20'h0_0000, `FES_RST_DATA};
    endcase
  endfunction : op_word

  always_comb
  begin
    next_r = r;
    next_r.rb_s1 = ready_busy_out;
    next_r.rb_s2 = r.rb_s1;
    // sector window age, counted from the end of the last erase write
    if (r.win)
    begin
      next_r.gap = r.gap + 16'h0001;
      if (r.gap >= WIN_LAST)
      begin
        next_r.win = 1'b0;
      end
    end
    // bus address phase
    next_r.ap_valid = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1])
    begin
      next_r.ap_wr = hwrite;
      next_r.ap_idx = haddr[7:2];
      case (haddr[7:2])
        `FES_REG_ADDR: next_r.hrdata = {12'h000, r.faddr};
        `FES_REG_STAT: next_r.hrdata = {28'h000_0000, r.win, r.refused,
          r.rb_s2, r.st != ST_IDLE};
        `FES_REG_RDATA: next_r.hrdata = {16'h0000, r.rdata};
        default: next_r.hrdata = 32'h0000_0000;
      endcase
    end
    // bus data phase: register writes
    if (r.ap_valid && r.ap_wr)
    begin
      if (r.ap_idx == `FES_REG_ADDR)
      begin
        next_r.faddr = hwdata[19:0];
      end
      else if (r.ap_idx == `FES_REG_CMD)
      begin
        if (r.st != ST_IDLE)
        begin
          next_r.refused = 1'b1;
        end
        else if (fes_op_e'(hwdata[3:0]) == OP_EXTRA
          && (!r.win || r.gap >= GAP_LIMIT))
        begin
          next_r.refused = 1'b1;
        end
        else if (fes_op_e'(hwdata[3:0]) == OP_NONE || hwdata[3:0] > 4'h8)
        begin
          next_r.refused = 1'b1;
        end
        else
        begin
          next_r.refused = 1'b0;
          next_r.op = fes_op_e'(hwdata[3:0]);
          next_r.step = 3'd0;
          next_r.rcnt = 16'h0000;
          next_r.st = (fes_op_e'(hwdata[3:0]) == OP_HWRST) ?
            ST_HWRST : ST_ISSUE;
        end
      end
    end
    case (r.st)
      ST_IDLE:
      begin
      end
      ST_ISSUE:
      begin
        next_r.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (cyc_done)
        begin
          if (r.op == OP_READ)
          begin
            next_r.rdata = cyc_rdata;
          end
          if (r.step == op_len(r.op) - 3'd1)
          begin
            next_r.st = ST_IDLE;
            if (r.op == OP_SECTOR || r.op == OP_EXTRA)
            begin
              next_r.win = 1'b1;
              next_r.gap = 16'h0000;
            end
            else if (r.op != OP_READ && r.op != OP_RESUME)
            begin
              next_r.win = 1'b0;
            end
          end
          else
          begin
            next_r.step = r.step + 3'd1;
            next_r.st = ST_ISSUE;
          end
        end
      end
      ST_HWRST:
      begin
        next_r.rcnt = r.rcnt + 16'h0001;
        next_r.win = 1'b0;
        if (r.rcnt == RST_LAST)
        begin
          next_r.st = ST_IDLE;
        end
      end
      default:
      begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign cyc_start = (r.st == ST_ISSUE);
  assign cyc_read = (r.op == OP_READ);
  assign cyc_word = op_word(r.op, r.step, r.faddr);
  assign hrdata = r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign flash_reset_n = (r.st != ST_HWRST);

  fes_bus_cycle u_cycle
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(cyc_start),
    .is_read(cyc_read),
    .addr(cyc_word[35:16]),
    .wdata(cyc_word[15:0]),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n)
  );

  AST_CHIP_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && r.op == OP_CHIP && r.step == 3'd0
    |-> cyc_word == {`FES_UNLOCK_A1, `FES_UNLOCK_D1})
    else $error("chip erase does not open with unlock");
  AST_CHIP_LAST: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && r.op == OP_CHIP && r.step == 3'd5
    |-> cyc_word[15:0] == `FES_CMD_CHIP && $past(r.step, 6) == 3'd4)
    else $error("chip erase sixth cycle wrong");
  AST_SETUP_CODE: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && r.step == 3'd2 |-> cyc_word[15:0] == `FES_CMD_SETUP)
    else $error("third cycle is not the set-up command");
  AST_SECTOR_LAST: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && r.op == OP_SECTOR && r.step == 3'd5
    |-> cyc_word == {r.faddr, `FES_CMD_SECTOR})
    else $error("sector erase sixth cycle wrong");
  AST_EXTRA_ONE: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && r.op == OP_EXTRA |-> r.step == 3'd0
    && cyc_word[15:0] == `FES_CMD_SECTOR)
    else $error("extra sector not a single sector cycle");
  AST_EXTRA_GAP: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && r.op == OP_EXTRA |-> r.gap < 16'(WIN_CYC) && r.win)
    else $error("extra sector issued outside the window");
  AST_WINDOW_CANCEL: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_done && (r.op == OP_RESET || r.op == OP_CHIP || r.op == OP_SUSPEND)
    && r.step == op_len(r.op) - 3'd1 |=> !r.win)
    else $error("window survives a cancelling command");
  AST_HWRST_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(flash_reset_n) |-> !flash_reset_n[*3] ##1 !r.win)
    else $error("hardware reset pulse too short");
endmodule : fes_ctrl

// ==== tb/fes_flash_model.sv ====
// behavioural flash answering the sequencer's erase command cycles
`timescale 1ns/100ps
module fes_flash_model #(
  parameter int WIN = 100,
  parameter int ERASE = 40
)
(
  input wire logic clk,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_i,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n,
  output logic ready_busy_out
);
  localparam logic [10:0] UA [6] = '{11'h555, 11'h2AA, 11'h555, 11'h555,
    11'h2AA, 11'h000};
  localparam logic [7:0] UD [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55,
    8'h00};
  logic [19:0] wa [$];
  logic [15:0] wd [$];
  // 0 read, 1 chip erase, 2 sector window, 3 sector erase, 4 suspended
  int st = 0;
  int seq = 0;
  int tmr = 0;
  logic we_q = 1'b1;
  logic [7:0] d;
  logic [15:0] rv;
  assign d = flash_dq_o[7:0];
  assign rv = flash_addr[15:0] ^ 16'h5A5A;
  // released bus shows the inverse, so a stale sample cannot match
  assign flash_dq_i = flash_oe_n ? ~rv : rv;
  assign ready_busy_out = !(st == 1 || st == 3);
  always @(posedge clk)
  begin
    we_q <= flash_we_n;
    if (!flash_reset_n)
    begin
      st <= 0;
      seq <= 0;
    end
    else if (flash_we_n && !we_q && !flash_ce_n)
    begin
      wa.push_back(flash_addr);
      wd.push_back(flash_dq_o);
      case (st)
        1: ;
        2: if (d == 8'h30) tmr <= 0;
           else st <= (d == 8'hB0) ? 4 : 0;
        3: if (d == 8'hB0) st <= 4;
        4: if (d == 8'h30) st <= 3;
        default:
          if (seq == 5 && d != 8'h30 && d != 8'h10) seq <= 0;
          else if (seq == 5)
          begin
            st <= (d == 8'h10) ? 1 : 2;
            tmr <= 0;
            seq <= 0;
          end
          else if (flash_addr[10:0] == UA[seq] && d == UD[seq]) seq <= seq + 1;
          else seq <= 0;
      endcase
    end
    else if (st == 2)
    begin
      st <= (tmr == WIN) ? 3 : 2;
      tmr <= (tmr == WIN) ? 0 : tmr + 1;
    end
    else if (st == 1 || st == 3)
    begin
      if (tmr == ERASE) st <= 0;
      tmr <= tmr + 1;
    end
  end
endmodule : fes_flash_model

// ==== tb/tb_fes_ctrl.sv ====
// self-checking bench for the erase sequencer over its register bus
`timescale 1ns/100ps
module tb_fes_ctrl;
  localparam int WIN = 100;
  localparam int HWR = 3;
  localparam logic [19:0] EA [5] = '{20'h0_0555, 20'h0_02AA, 20'h0_0555,
    20'h0_0555, 20'h0_02AA};
  localparam logic [15:0] ED [5] = '{16'h00AA, 16'h0055, 16'h0080,
    16'h00AA, 16'h0055};
  typedef struct {
    logic [3:0] cmd;
    logic [19:0] addr;
    int nwr;
    logic [15:0] ld;
    logic refd;
  } fes_row_s;
  fes_row_s rows [13] = '{
    '{4'h1, 20'h0_0555, 6, 16'h0010, 1'b0},
    '{4'h2, 20'h1_2000, 6, 16'h0030, 1'b0},
    '{4'h3, 20'h0_8000, 1, 16'h0030, 1'b0},
    '{4'h3, 20'h0_4000, 1, 16'h0030, 1'b0},
    '{4'h4, 20'h0_0000, 1, 16'h00B0, 1'b0},
    '{4'h3, 20'h0_2000, 0, 16'h0000, 1'b1},
    '{4'h5, 20'h0_0000, 1, 16'h0030, 1'b0},
    '{4'h6, 20'h0_0000, 1, 16'h00F0, 1'b0},
    '{4'h0, 20'h0_0000, 0, 16'h0000, 1'b1},
    '{4'h9, 20'h0_0000, 0, 16'h0000, 1'b1},
    '{4'h2, 20'h3_F000, 6, 16'h0030, 1'b0},
    '{4'h6, 20'h0_0000, 1, 16'h00F0, 1'b0},
    '{4'h3, 20'h0_1000, 0, 16'h0000, 1'b1}};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq_o, flash_dq_i;
  logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  logic flash_reset_n, ready_busy_out;
  int error_cnt = 0;
  int cmp_count = 0;
  int lo_cnt = 0;
  always #10 clk = ~clk;
  always @(posedge clk) if (flash_reset_n === 1'b0) lo_cnt <= lo_cnt + 1;
  fes_ctrl #(.WIN_CYC(WIN), .HWRST_CYC(HWR)) dut (.clk, .sys_rst, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i,
    .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n, .ready_busy_out);
  fes_flash_model #(.WIN(WIN)) fm (.clk, .flash_addr, .flash_dq_o,
    .flash_dq_i, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n,
    .ready_busy_out);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic end_of_test;
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic ahb(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] r);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  // waits for both the sequencer and the flash to be idle; two idle polls
  // in a row, since the synced ready bit lags the sequencer's busy bit by a cycle
  task automatic wait_idle(output logic [31:0] s);
    int n;
    int ok;
    n = 0;
    ok = 0;
    do
    begin
      ahb(1'b0, 32'h0000_0008, 32'h0000_0000, s);
      n++;
      ok = (s[0] === 1'b0 && s[1] === 1'b1) ? ok + 1 : 0;
    end
    while (ok < 2 && n < 500);
    if (ok < 2) chk(32'(ok), 32'h0000_0002);
  endtask : wait_idle
  task automatic op(input logic [3:0] c, input logic [19:0] a,
    output logic [31:0] s);
    logic [31:0] r;
    ahb(1'b1, 32'h0000_0004, {12'h000, a}, r);
    ahb(1'b1, 32'h0000_0000, {28'h000_0000, c}, r);
    wait_idle(s);
  endtask : op
  initial
  begin : main
    logic [31:0] r, s;
    int n0, j;
    repeat (16) @(posedge clk);
    chk({flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, flash_dq_oe,
      hreadyout, hresp}, 32'h0000_007A);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000, s);
    chk(s & 32'h0000_000F, 32'h0000_0002);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    foreach (rows[i])
    begin
      n0 = fm.wa.size();
      op(rows[i].cmd, rows[i].addr, s);
      chk({31'h0, s[2]}, {31'h0, rows[i].refd});
      chk(32'(fm.wa.size() - n0), 32'(rows[i].nwr));
      for (int k = 0; k < rows[i].nwr; k++)
      begin
        j = k + 6 - rows[i].nwr;
        chk(32'(fm.wd[n0 + k]), j < 5 ? 32'(ED[j]) : 32'(rows[i].ld));
        if (j < 5 || rows[i].cmd inside {4'h1, 4'h2, 4'h3})
          chk(32'(fm.wa[n0 + k]), j < 5 ? 32'(EA[j]) : 32'(rows[i].addr));
      end
    end
    n0 = fm.wa.size();
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001, r);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0002, r);
    wait_idle(s);
    chk({31'h0, s[2]}, 32'h0000_0001);
    chk(32'(fm.wa.size() - n0), 32'h0000_0006);
    op(4'h2, 20'h0_5000, s);
    chk({31'h0, s[3]}, 32'h0000_0001);
    repeat (WIN) @(posedge clk);
    n0 = fm.wa.size();
    op(4'h3, 20'h0_6000, s);
    chk({30'h0, s[3:2]}, 32'h0000_0001);
    chk(32'(fm.wa.size() - n0), 32'h0000_0000);
    op(4'h7, 20'h0_0123, s);
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000, r);
    chk(r, 32'h0000_5B79);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000, r);
    chk(r, 32'h0000_0123);
    op(4'h2, 20'h0_7000, s);
    n0 = lo_cnt;
    op(4'h8, 20'h0_0000, s);
    chk(32'(lo_cnt - n0), 32'(HWR));
    chk({31'h0, s[3]}, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001, r);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    chk({flash_ce_n, flash_we_n, flash_dq_oe}, 32'h0000_0006);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    n0 = fm.wa.size();
    op(4'h2, 20'h0_7000, s);
    chk(32'(fm.wa.size() - n0), 32'h0000_0006);
    end_of_test();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule : tb_fes_ctrl
